/* irq_agg_pkg.sv */
package irq_agg_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************

	// Byte offsets of the three registers on the bus.
	localparam logic [7:0] FLAGS_OFFSET   = 8'ha0;
	localparam logic [7:0] ENABLES_OFFSET = 8'ha4;
	localparam logic [7:0] SLEEP_OFFSET   = 8'h9c;

	// Number of implemented event bits and register width.
	localparam int EVENT_COUNT = 8;
	localparam int REG_WIDTH   = 16;

	// Bit positions of the eight events.
	localparam int MICROFRAME_START_BIT = 0;
	localparam int FRAME_START_BIT      = 1;
	localparam int TRANSFER_DONE_BIT    = 2;
	localparam int REMOTE_WAKE_BIT      = 3;
	localparam int BUS_IDLE_BIT         = 4;
	localparam int CLOCK_STABLE_BIT     = 5;
	localparam int OVERCURRENT_BIT      = 6;
	localparam int CONNECT_WAKE_BIT     = 7;

	// Values after reset.
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [7:0]  ENABLES_RESET = 8'h00;
	localparam logic [15:0] SLEEP_RESET   = 16'h0400;

endpackage : irq_agg_pkg

/* event_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Carries raw event levels in and one-cycle event pulses out.
interface event_sync_if #(parameter int N = 8);
	logic [N-1:0] raw;
	logic [N-1:0] pulse;
	modport syncer (input raw, output pulse);
	modport user   (output raw, input pulse);
endinterface : event_sync_if

`default_nettype wire

/* event_sync.sv */
`timescale 1ns/100ps
`default_nettype none

// Brings event levels into the clock domain and marks their rising edges.
module event_sync #(
	parameter int N = 8
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst,
	// Event lines
	event_sync_if.syncer       ev
);

	logic [N-1:0] meta_reg;
	logic [N-1:0] stable_reg;
	logic [N-1:0] prev_reg;

	// Two flip-flops, then a third stage for edge detection.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_reg   <= '0;
			stable_reg <= '0;
			prev_reg   <= '0;
		end else begin
			meta_reg   <= ev.raw;
			stable_reg <= meta_reg;
			prev_reg   <= stable_reg;
		end
	end

	// A pulse marks each low-to-high change.
	assign ev.pulse = stable_reg & ~prev_reg;

endmodule : event_sync
`default_nettype wire

/* sleep_timer.sv */
`timescale 1ns/100ps
`default_nettype none

// Counts down while the bus is idle and pulses once on reaching zero.
module sleep_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst,
	// Control
	input  wire logic [W-1:0]  reload,
	input  wire logic          bus_active,
	// Result
	output logic               expired
);

	logic [W-1:0] count_reg;
	logic         done_reg;

	// Reload on activity; count while idle; fire once at zero.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_reg <= irq_agg_pkg::SLEEP_RESET;
			done_reg  <= 1'b0;
			expired   <= 1'b0;
		end else if (bus_active) begin
			count_reg <= reload;
			done_reg  <= 1'b0;
			expired   <= 1'b0;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
			expired   <= 1'b0;
		end else begin
			expired  <= ~done_reg;
			done_reg <= 1'b1;
		end
	end

endmodule : sleep_timer
`default_nettype wire

/* usb_host_irq_aggregator.sv */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [RULE1] Connect or disconnect wake sets bit 7
// [RULE2] Overcurrent sets bit 6
// [RULE3] Clock stable sets bit 5
// [RULE4] Bus idle sets bit 4
// [RULE5] Remote wake sets bit 3
// [RULE6] Transfer done sets bit 2
// [RULE7] Frame start sets bit 1, gated; the code sets bit 1 on each frame start whatever enable bit 1 holds
// [RULE8] Microframe start sets bit 0
// [RULE9] Enable bit 7 gates connect wake
// [RULE10] Enable bit 6 gates overcurrent
// [RULE11] Enable bit 5 gates clock stable
// [RULE12] Enable bit 4 gates bus idle
// [RULE13] Enable bit 3 gates remote wake
// [RULE14] Enable bit 2 gates transfer done
// [RULE15] Enable bit 1 gates frame start
// [RULE16] Enable bit 0 gates microframe start
// [RULE17] Idle countdown reaching zero flags bus idle
// [RULE18] Flags sticky until written one; reserved zero
// [RULE19] Interrupt is OR of flags and enables
module usb_host_irq_aggregator (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Event inputs from the controller
	input  wire logic        connect_wake_evt,
	input  wire logic        overcurrent_evt,
	input  wire logic        clock_stable_evt,
	input  wire logic        remote_wake_evt,
	input  wire logic        transfer_done_evt,
	input  wire logic        frame_start_evt,
	input  wire logic        microframe_start_evt,
	input  wire logic        bus_active,
	// Interrupt to the processor
	output logic             irq
);

	// ****************************************************************
	// Event capture
	// ****************************************************************

	event_sync_if #(.N(8)) ev ();
	logic [7:0]  event_pulse;
	logic        idle_expired;
	logic        bus_active_meta_reg;
	logic        bus_active_reg;

	// Event lines packed in register bit order; bus idle comes from the timer.
	assign ev.raw = {connect_wake_evt, overcurrent_evt, clock_stable_evt, 1'b0,
		remote_wake_evt, transfer_done_evt, frame_start_evt, microframe_start_evt};

	event_sync #(
		.N (8)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.ev       (ev.syncer)
	);

	// Bus activity passes two flip-flops before the timer sees it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_active_meta_reg <= 1'b1;
			bus_active_reg      <= 1'b1;
		end else begin
			bus_active_meta_reg <= bus_active;
			bus_active_reg      <= bus_active_meta_reg;
		end
	end

	// ****************************************************************
	// Sleep timer
	// ****************************************************************

	logic [15:0] sleep_reload_reg;

	sleep_timer #(
		.W (16)
	) u_timer (
		.core_clk   (core_clk),
		.rst        (rst),
		.reload     (sleep_reload_reg),
		.bus_active (bus_active_reg),
		.expired    (idle_expired)
	);

	// Per-bit set requests from all sources.
	always_comb begin
		event_pulse = ev.pulse;
		event_pulse[irq_agg_pkg::BUS_IDLE_BIT] = idle_expired; // RULE17 RULE4
	end

	// ****************************************************************
	// Bus decode
	// ****************************************************************

	logic        bus_req;
	logic        wr_strobe;
	logic        hit_flags;
	logic        hit_enables;
	logic        hit_sleep;
	logic [15:0] wr_low;

	// A request is served once; ack drops in the cycle after it was given.
	assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_strobe = bus_req & wb_we_i;

	// Address decoding on the word-aligned offset.
	always_comb begin
		hit_flags   = 1'b0;
		hit_enables = 1'b0;
		hit_sleep   = 1'b0;
		if (wb_adr_i == irq_agg_pkg::FLAGS_OFFSET) begin
			hit_flags = 1'b1;
		end else if (wb_adr_i == irq_agg_pkg::ENABLES_OFFSET) begin
			hit_enables = 1'b1;
		end else if (wb_adr_i == irq_agg_pkg::SLEEP_OFFSET) begin
			hit_sleep = 1'b1;
		end
	end

	// Lower two byte lanes of write data, masked by select.
	assign wr_low = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ****************************************************************
	// Registers
	// ****************************************************************

	logic [7:0] irq_event_flags_reg;
	logic [7:0] irq_event_flags_next;
	logic [7:0] irq_event_enables_reg;
	logic [7:0] write_clear;

	// Write-one-to-clear mask; bits 15:8 are reserved and ignored.
	assign write_clear = (wr_strobe && hit_flags) ? wr_low[7:0] : 8'h00; // RULE18

	// A new event wins over a clear in the same cycle.
	assign irq_event_flags_next = (irq_event_flags_reg & ~write_clear) | event_pulse; // RULE1 RULE2 RULE3 RULE5 RULE6 RULE7 RULE8 RULE18

	// Sticky status flags.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_event_flags_reg <= irq_agg_pkg::FLAGS_RESET;
		end else begin
			irq_event_flags_reg <= irq_event_flags_next; // RULE18
		end
	end

	// Enable register, writable on its low byte lane.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_event_enables_reg <= irq_agg_pkg::ENABLES_RESET;
		end else if (wr_strobe && hit_enables && wb_sel_i[0]) begin
			irq_event_enables_reg <= wb_dat_i[7:0];
		end
	end

	// Sleep timer reload value, per byte lane.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sleep_reload_reg <= irq_agg_pkg::SLEEP_RESET;
		end else if (wr_strobe && hit_sleep) begin
			if (wb_sel_i[0]) begin
				sleep_reload_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				sleep_reload_reg[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// ****************************************************************
	// Bus answer
	// ****************************************************************

	// One-cycle ack; unmapped reads return zero, unmapped writes are dropped.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				if (hit_flags) begin
					wb_dat_o <= {24'h00_0000, irq_event_flags_reg}; // RULE18
				end else if (hit_enables) begin
					wb_dat_o <= {24'h00_0000, irq_event_enables_reg};
				end else if (hit_sleep) begin
					wb_dat_o <= {16'h0000, sleep_reload_reg};
				end
			end
		end
	end

	// ****************************************************************
	// Interrupt output
	// ****************************************************************

	// Each flag reaches the line only through its enable bit.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_event_flags_reg & irq_event_enables_reg); // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE16 RULE19
		end
	end

endmodule : usb_host_irq_aggregator
`default_nettype wire

/* irq_agg_props.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************
// Port checker
// ****************
module irq_agg_props (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Events and interrupt
	input wire logic        connect_wake_evt,
	input wire logic        overcurrent_evt,
	input wire logic        clock_stable_evt,
	input wire logic        remote_wake_evt,
	input wire logic        transfer_done_evt,
	input wire logic        frame_start_evt,
	input wire logic        microframe_start_evt,
	input wire logic        bus_active,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] evv;
	logic [7:0] en_m;
	// Event lines gathered by flag bit position.
	assign evv = {connect_wake_evt, overcurrent_evt, clock_stable_evt, 1'b0,
		remote_wake_evt, transfer_done_evt, frame_start_evt, microframe_start_evt};
	// Shadow of the enable register, taken from finished writes.
	always_ff @(posedge core_clk) begin
		if (rst)
			en_m <= 8'h00;
		else if (wb_ack_o && wb_we_i && wb_adr_i == 8'ha4 && wb_sel_i[0])
			en_m <= wb_dat_i[7:0];
	end
	sequence wb_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	ack_resp_a: assert property (wb_take |=> wb_ack_o) else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
	rsvd_zero_a: assert property (wb_ack_o && (wb_adr_i == 8'ha0 || wb_adr_i == 8'ha4) |->
		wb_dat_o[31:8] == 24'h0) else $error("reserved bits set");
	irq_clear_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
		else $error("irq fell without write");
	no_irq_a: assert property ((en_m == 8'h00) [*3] |-> !irq)
		else $error("irq with no enable");
	for (genvar i = 0; i < 8; i++) begin : g_ev
		evt_irq_a: assert property ($rose(evv[i]) && en_m[i] |-> ##[2:8] irq)
			else $error("event gave no irq");
	end
endmodule // irq_agg_props

bind usb_host_irq_aggregator irq_agg_props u_props (
	.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .connect_wake_evt(connect_wake_evt),
	.overcurrent_evt(overcurrent_evt), .clock_stable_evt(clock_stable_evt),
	.remote_wake_evt(remote_wake_evt), .transfer_done_evt(transfer_done_evt),
	.frame_start_evt(frame_start_evt), .microframe_start_evt(microframe_start_evt),
	.bus_active(bus_active), .irq(irq));

`default_nettype wire

/* irq_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Processor side: counts each new interrupt request it sees.
module irq_host_model (
	// Clock and line
	input  wire logic core_clk,
	input  wire logic irq,
	// Count
	output var int    irq_seen
);
	logic irq_q = 1'b0;
	int   seen_cnt = 0;
	// Rising edges of the line are counted once each.
	always @(posedge core_clk) begin
		if (irq === 1'b1 && irq_q === 1'b0)
			seen_cnt <= seen_cnt + 1;
		irq_q <= irq;
	end
	// The count has a single driver; the port only shows it.
	assign irq_seen = seen_cnt;
endmodule // irq_host_model

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error %0t: got %h expected %h", $time, a, b); end end

module tb_top;
	logic core_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, bus_act = 1'b1;
	logic [7:0] adr = 8'h00, ev = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, irq;
	int error_cnt = 0, samples_checked = 0, irq_seen, nirq = 0;
	// Clock of 100 ns period.
	always #50 core_clk = ~core_clk;
	usb_host_irq_aggregator u_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .connect_wake_evt(ev[7]), .overcurrent_evt(ev[6]),
		.clock_stable_evt(ev[5]), .remote_wake_evt(ev[3]), .transfer_done_evt(ev[2]),
		.frame_start_evt(ev[1]), .microframe_start_evt(ev[0]), .bus_active(bus_act), .irq(irq));
	irq_host_model u_host (.core_clk(core_clk), .irq(irq), .irq_seen(irq_seen));
	// One bus cycle, held until acknowledged.
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 20);
		if (n >= 20) `CHK(ack, 1'b1)
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		repeat (8) @(posedge core_clk);
		ev[i] <= 1'b0;
		@(posedge core_clk);
	endtask
	// Reset values, write masking and an unmapped place.
	task automatic t_regs;
		wb(8'ha0, 0, 0); `CHK(q, 32'h0)
		wb(8'h9c, 0, 0); `CHK(q, 32'h400)
		wb(8'ha4, 1, 32'hffffffff); wb(8'ha4, 0, 0); `CHK(q, 32'hff)
		wb(8'h10, 1, 32'hffffffff); wb(8'h10, 0, 0); `CHK(q, 32'h0)
		wb(8'ha4, 1, 0);
	endtask
	// Each event but bus idle: masked flag, clear, then enabled interrupt.
	task automatic t_events;
		for (int i = 0; i < 8; i++) if (i != 4) begin
			pulse(i); wb(8'ha0, 0, 0); `CHK(q, 32'h1 << i)
			`CHK(irq, 1'b0)
			wb(8'ha0, 1, 32'h1 << i); wb(8'ha0, 0, 0); `CHK(q, 32'h0)
			wb(8'ha4, 1, 32'h1 << i); pulse(i); `CHK(irq, 1'b1)
			wb(8'ha0, 1, 32'h1 << i); repeat (2) @(posedge core_clk); `CHK(irq, 1'b0)
			nirq++;
		end
		wb(8'ha4, 1, 0);
	endtask
	// Idle bus with a short reload sets the idle flag.
	task automatic t_idle;
		wb(8'h9c, 1, 32'h4); wb(8'ha4, 1, 32'h10); bus_act <= 1'b0;
		repeat (20) @(posedge core_clk);
		wb(8'ha0, 0, 0); `CHK(q, 32'h10)
		`CHK(irq, 1'b1)
		bus_act <= 1'b1; nirq++;
		wb(8'ha0, 1, 32'h10); repeat (2) @(posedge core_clk); `CHK(irq, 1'b0)
		`CHK(irq_seen, nirq)
	endtask
	task automatic print_verdict;
		$display("Checks made %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_regs(); t_events(); t_idle();
		print_verdict();
	end
	initial begin
		#2000000;
		error_cnt++;
		print_verdict();
	end
endmodule // tb_top

`default_nettype wire
